// [smbse_consts.vh]
// Constants for the SMBus slave with nonvolatile memory access
`ifndef SMBSE_CONSTS_VH
`define SMBSE_CONSTS_VH
`define SMBSE_ADDR_FIXED     5'h11
`define SMBSE_NV_BASE_HI     8'hf8
`define SMBSE_NV_LAST_HI     8'hfb
`define SMBSE_NV_SE_HI       8'hfa
`define SMBSE_NV_CFG_END     16'hf89f
`define SMBSE_NV_RSV_FIRST   16'hf8a0
`define SMBSE_NV_RSV_LAST    16'hf8ff
`define SMBSE_NV_LOW_LAST    16'hf9ff
`define SMBSE_NV_SE_FIRST    16'hfa00
`define SMBSE_NV_AW          10
`define SMBSE_PAGE_BYTES     32
`define SMBSE_PAGE_AW        5
`define SMBSE_CFG_PAGES      5
`define SMBSE_CFG_BYTES      8'ha0
`define SMBSE_REG_UPDATE_CONFIGURATION     8'h90
`define SMBSE_UPDATE_CONFIGURATION_ERASE   2
`define SMBSE_REG_DOWNLOAD   8'hd8
`define SMBSE_DOWNLOAD_BIT   0
`define SMBSE_REG_MAKER      8'hf4
`define SMBSE_REG_REV        8'hf5
`define SMBSE_REG_BRAND1     8'hf6
`define SMBSE_REG_BRAND2     8'hf7
`define SMBSE_RAM_LAST       8'hdf
`define SMBSE_CMD_ERASE      8'hfe
`define SMBSE_CMD_BLOCK      8'hfc
`define SMBSE_ERASED_BYTE    8'hff
`define SMBSE_LOAD_TIME_US   1000
`define SMBSE_CLK_MHZ        200
`endif

// [smbse_mem.v]
// Single-port byte memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module smbse_mem #(
  parameter AW = 10
) (
  input  wire          i_clk,
  input  wire          i_ce,
  input  wire          i_we,
  input  wire [AW-1:0] i_addr,
  input  wire [7:0]    i_wdata,
  output reg  [7:0]    o_rdata
);
  reg [7:0] mem_r [0:(1<<AW)-1];
  always @(posedge i_clk)
  begin
    if (i_ce)
    begin
      if (i_we)
        mem_r[i_addr] <= i_wdata;
      o_rdata <= mem_r[i_addr];
    end
  end
endmodule // smbse_mem
`default_nettype wire

// [smbse_slave.v]
// SMBus slave with nonvolatile memory map, download and access gating
`timescale 1ns/1ps
`default_nettype none
`include "smbse_consts.vh"
module smbse_slave #(
  parameter LOAD_CYCLES = `SMBSE_LOAD_TIME_US * `SMBSE_CLK_MHZ,
  parameter [7:0] MAKER_CODE = 8'h5a,  // Arbitrary value
  parameter [7:0] SILICON_REV = 8'h01, // Arbitrary value
  parameter [7:0] BRAND_FIRST = 8'h11, // Arbitrary value
  parameter [7:0] BRAND_SECOND = 8'h22 // Arbitrary value
) (
  input  wire       i_clk,
  input  wire       i_rst_n,
  input  wire       i_ce,
  input  wire       i_scl,
  input  wire       i_sda,
  output wire       o_sda,
  output wire       o_sda_oe,
  input  wire       i_addr_strap_high,
  input  wire       i_addr_strap_low,
  input  wire       i_seq_running,
  input  wire       i_rec_enabled,
  input  wire       i_rec_has_trigger,
  output reg  [7:0] o_cfg_addr,
  output reg  [7:0] o_cfg_data,
  output reg        o_cfg_we,
  output reg        o_load_busy,
  output reg  [7:0] o_update_cfg
);
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_ADDR = 6'h02;
  localparam [5:0] ST_RX   = 6'h04;
  localparam [5:0] ST_TX   = 6'h08;
  localparam [5:0] ST_ACK  = 6'h10;
  localparam [5:0] ST_SKIP = 6'h20;

  // Two-flop sync; first stage read only by the second
  reg [1:0] scl_s_r, sda_s_r, strap_s_r;
  reg [1:0] strap_q_r;
  reg       scl_d_r, sda_d_r;
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      strap_s_r <= 2'h0;
      strap_q_r <= 2'h0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else if (i_ce)
    begin
      scl_s_r <= {scl_s_r[0], i_scl};
      sda_s_r <= {sda_s_r[0], i_sda};
      strap_s_r <= {i_addr_strap_high, i_addr_strap_low};
      strap_q_r <= strap_s_r;
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end
  wire scl = scl_s_r[1];
  wire sda = sda_s_r[1];
  wire scl_rise = scl & ~scl_d_r;
  wire scl_fall = ~scl & scl_d_r;
  wire start_c = scl & scl_d_r & sda_d_r & ~sda;
  wire stop_c  = scl & scl_d_r & ~sda_d_r & sda;
  wire [6:0] own_addr = {`SMBSE_ADDR_FIXED, strap_q_r};

  // Nonvolatile store and download engine
  reg  [5:0]  st_r;
  reg  [3:0]  bit_r;
  reg  [7:0]  sh_r;
  reg         rd_r, ack_r, drive_r, mack_r;
  reg  [2:0]  byte_r;
  reg  [7:0]  cmd_r, cnt_r;
  reg  [15:0] ptr_r;
  reg         blk_r;
  reg  [23:0] load_cnt_r;
  reg         dl_r;
  reg  [7:0]  dl_idx_r;
  reg         dl_rd_r;
  reg         mem_we;
  reg  [9:0]  mem_addr;
  reg  [7:0]  mem_wdata;
  reg         erase_r;
  reg  [4:0]  erase_cnt_r;
  reg  [9:0]  erase_base_r;
  wire [7:0]  mem_rdata;

  smbse_mem #(.AW(`SMBSE_NV_AW)) u_mem (
    .i_clk   (i_clk),
    .i_ce    (i_ce),
    .i_we    (mem_we),
    .i_addr  (mem_addr),
    .i_wdata (mem_wdata),
    .o_rdata (mem_rdata)
  );

  function is_nv;
    input [15:0] a;
    is_nv = (a[15:8] >= `SMBSE_NV_BASE_HI) && (a[15:8] <= `SMBSE_NV_LAST_HI);
  endfunction
  function is_se;
    input [15:0] a;
    is_se = is_nv(a) && (a >= `SMBSE_NV_SE_FIRST);
  endfunction

  wire rec_active = i_rec_enabled & i_rec_has_trigger;
  wire low_gated  = rec_active & is_nv(ptr_r) & ~is_se(ptr_r);
  wire se_refused = i_seq_running & is_se(ptr_r);
  wire in_rsv     = (ptr_r >= `SMBSE_NV_RSV_FIRST) && (ptr_r <= `SMBSE_NV_RSV_LAST);
  wire busy       = o_load_busy | dl_r | erase_r;
  // Refuse while loading, downloading or erasing, or while the sequencer-locked region is addressed
  wire addr_nack  = (sh_r[7:1] != own_addr) | (sh_r[0] & se_refused);
  wire data_nack  = (byte_r >= 3'h2) & se_refused;
  wire nack_c     = busy | ((st_r == ST_ADDR) ? addr_nack : data_nack);

  // Byte accept for write data
  wire       nv_wr_ok = is_nv(ptr_r) & ~low_gated & ~se_refused & ~in_rsv;
  reg  [7:0] id_val;
  always @*
  begin
    case (ptr_r[7:0])
      `SMBSE_REG_MAKER:  id_val = MAKER_CODE;
      `SMBSE_REG_REV:    id_val = SILICON_REV;
      `SMBSE_REG_BRAND1: id_val = BRAND_FIRST;
      `SMBSE_REG_BRAND2: id_val = BRAND_SECOND;
      `SMBSE_REG_UPDATE_CONFIGURATION: id_val = o_update_cfg;
      default:           id_val = 8'h00;
    endcase
  end
  wire [7:0] tx_byte = low_gated ? 8'h00 : (is_nv(ptr_r) ? mem_rdata : id_val);

  always @*
  begin
    mem_we = 1'b0;
    mem_wdata = `SMBSE_ERASED_BYTE;
    mem_addr = ptr_r[9:0];
    if (erase_r)
    begin
      mem_we = 1'b1;
      mem_addr = erase_base_r | {5'h00, erase_cnt_r};
    end
    else if (dl_r)
      mem_addr = {2'h0, dl_idx_r};
    // Byte 2 is the low address or the block count; data starts at byte 3
    else if (st_r == ST_ACK && !rd_r && byte_r >= 3'h3 && !ack_r && nv_wr_ok
             && scl_fall)
    begin
      // Program only a blank location; a location already written keeps its value
      mem_we = (mem_rdata == `SMBSE_ERASED_BYTE);
      mem_wdata = sh_r;
    end
  end

  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st_r <= ST_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      rd_r <= 1'b0;
      ack_r <= 1'b0;
      drive_r <= 1'b0;
      mack_r <= 1'b0;
      byte_r <= 3'h0;
      cmd_r <= 8'h00;
      cnt_r <= 8'h00;
      ptr_r <= 16'h0000;
      blk_r <= 1'b0;
      load_cnt_r <= 24'h000000;
      o_load_busy <= 1'b1;
      dl_r <= 1'b0;
      dl_idx_r <= 8'h00;
      dl_rd_r <= 1'b0;
      o_cfg_addr <= 8'h00;
      o_cfg_data <= 8'h00;
      o_cfg_we <= 1'b0;
      o_update_cfg <= 8'h00;
      erase_r <= 1'b0;
      erase_cnt_r <= 5'h00;
      erase_base_r <= 10'h000;
    end
    else if (i_ce)
    begin
      o_cfg_we <= 1'b0;
      // Power-up settle, then first download of pages 0-4
      if (o_load_busy)
      begin
        if (load_cnt_r == LOAD_CYCLES[23:0] - 24'h1)
        begin
          o_load_busy <= 1'b0;
          dl_r <= 1'b1;
          dl_idx_r <= 8'h00;
          dl_rd_r <= 1'b0;
        end
        else
          load_cnt_r <= load_cnt_r + 24'h1;
      end
      if (dl_r)
      begin
        // Read data lags the address by one cycle
        dl_rd_r <= 1'b1;
        if (dl_rd_r)
        begin
          o_cfg_we <= 1'b1;
          o_cfg_addr <= dl_idx_r - 8'h1;
          o_cfg_data <= mem_rdata;
        end
        if (dl_idx_r == `SMBSE_CFG_BYTES)
          dl_r <= 1'b0;
        else
          dl_idx_r <= dl_idx_r + 8'h1;
      end
      if (erase_r)
      begin
        erase_cnt_r <= erase_cnt_r + 5'h1;
        if (erase_cnt_r == 5'h1f)
          erase_r <= 1'b0;
      end

      if (start_c)
      begin
        st_r <= ST_ADDR;
        bit_r <= 4'h0;
        drive_r <= 1'b0;
        byte_r <= 3'h0;
      end
      else if (stop_c)
      begin
        st_r <= ST_IDLE;
        drive_r <= 1'b0;
        // Erase fires once the command frame closes
        if (!rd_r && byte_r == 3'h2 && cmd_r == `SMBSE_CMD_ERASE
            && o_update_cfg[`SMBSE_UPDATE_CONFIGURATION_ERASE] && nv_wr_ok && !busy)
        begin
          erase_r <= 1'b1;
          erase_cnt_r <= 5'h00;
          erase_base_r <= {ptr_r[9:`SMBSE_PAGE_AW], 5'h00};
        end
      end
      else
      begin
        case (st_r)
          ST_IDLE: drive_r <= 1'b0;
          ST_ADDR, ST_RX:
          begin
            if (scl_rise)
            begin
              sh_r <= {sh_r[6:0], sda};
              bit_r <= bit_r + 4'h1;
            end
            if (scl_fall && bit_r == 4'h8)
            begin
              bit_r <= 4'h0;
              if (st_r == ST_ADDR)
                rd_r <= sh_r[0];
              // Flag and pin share one decision so a NACKed byte is never used
              ack_r <= nack_c;
              drive_r <= ~nack_c;
              st_r <= ST_ACK;
            end
          end
          ST_ACK:
          begin
            if (scl_fall)
            begin
              drive_r <= 1'b0;
              bit_r <= 4'h0;
              if (ack_r)
                st_r <= ST_SKIP;
              else if (byte_r == 3'h0)
              begin
                byte_r <= 3'h1;
                st_r <= rd_r ? ST_TX : ST_RX;
                if (rd_r)
                begin
                  drive_r <= ~tx_byte[7];
                  sh_r <= tx_byte;
                end
              end
              else
              begin
                st_r <= ST_RX;
                if (byte_r != 3'h7)
                  byte_r <= byte_r + 3'h1;
                if (byte_r == 3'h1)
                begin
                  cmd_r <= sh_r;
                  blk_r <= (sh_r == `SMBSE_CMD_BLOCK);
                  if (sh_r >= `SMBSE_NV_BASE_HI && sh_r <= `SMBSE_NV_LAST_HI)
                    ptr_r <= {sh_r, 8'h00};
                  else if (sh_r != `SMBSE_CMD_BLOCK && sh_r != `SMBSE_CMD_ERASE)
                    ptr_r <= {8'h00, sh_r};
                end
                else if (blk_r && byte_r == 3'h2)
                  cnt_r <= sh_r;
                else if (is_nv(ptr_r) && byte_r == 3'h2)
                  ptr_r <= {ptr_r[15:8], sh_r};
                else
                begin
                  if (!is_nv(ptr_r))
                  begin
                    if (ptr_r[7:0] == `SMBSE_REG_UPDATE_CONFIGURATION)
                      o_update_cfg <= sh_r;
                    else if (ptr_r[7:0] == `SMBSE_REG_DOWNLOAD
                             && sh_r[`SMBSE_DOWNLOAD_BIT] && !dl_r)
                    begin
                      dl_r <= 1'b1;
                      dl_idx_r <= 8'h00;
                      dl_rd_r <= 1'b0;
                    end
                    else if (ptr_r[7:0] <= `SMBSE_RAM_LAST)
                    begin
                      o_cfg_we <= 1'b1;
                      o_cfg_addr <= ptr_r[7:0];
                      o_cfg_data <= sh_r;
                    end
                    // Identification writes fall through unchanged
                  end
                  ptr_r <= ptr_r + 16'h1;
                end
              end
            end
          end
          ST_TX:
          begin
            if (scl_fall)
            begin
              bit_r <= bit_r + 4'h1;
              if (bit_r == 4'h7)
                drive_r <= 1'b0;
              else
              begin
                sh_r <= {sh_r[6:0], 1'b0};
                drive_r <= ~sh_r[6];
              end
              if (bit_r == 4'h8)
              begin
                // Master NACK ends the read; ACK reloads next byte
                if (mack_r)
                begin
                  st_r <= ST_SKIP;
                  drive_r <= 1'b0;
                end
                else
                begin
                  bit_r <= 4'h0;
                  sh_r <= tx_byte;
                  drive_r <= ~tx_byte[7];
                end
              end
            end
            if (scl_rise && bit_r == 4'h8)
            begin
              mack_r <= sda;
              if (!sda)
                ptr_r <= ptr_r + 16'h1;
            end
          end
          ST_SKIP: drive_r <= 1'b0;
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end

  // Open drain: only ever pulls low
  assign o_sda    = 1'b0;
  assign o_sda_oe = drive_r;
endmodule // smbse_slave
`default_nettype wire

// [smbse_slave_asserts.sv]
// Port-level assertions for the SMBus slave block
`timescale 1ns/1ps
`default_nettype none
module smbse_slave_chk #(
  parameter LOAD_CYCLES = 400
) (
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_ce,
  input wire logic       i_scl,
  input wire logic       o_sda,
  input wire logic       o_sda_oe,
  input wire logic [7:0] o_cfg_addr,
  input wire logic       o_cfg_we,
  input wire logic       o_load_busy
);
  logic [31:0] since_rst_r;
  // Saturates so a long run never wraps back into the load window
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
      since_rst_r <= 32'h0;
    else if (i_ce && since_rst_r != 32'hffffffff)
      since_rst_r <= since_rst_r + 32'h1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  reset_quiet_a: assert property ($rose(i_rst_n) |-> o_load_busy && !o_sda_oe && !o_cfg_we)
    else $error("outputs active right after reset");
  busy_nack_a: assert property (o_load_busy |-> !o_sda_oe)
    else $error("bus answered during load");
  load_hold_a: assert property (since_rst_r + 32'h2 < LOAD_CYCLES |-> o_load_busy)
    else $error("load ended early");
  ack_rise_a: assert property ($rose(o_sda_oe) |-> !i_scl)
    else $error("data line pulled while clock high");
  ack_fall_a: assert property ($fell(o_sda_oe) |-> !i_scl)
    else $error("data line released while clock high");
  ack_steady_a: assert property (i_scl && $past(i_scl, 3) |-> $stable(o_sda_oe))
    else $error("data drive moved in clock high phase");
  open_drain_a: assert property (o_sda == 1'b0)
    else $error("data output not low");
  cfg_range_a: assert property (o_cfg_we |-> o_cfg_addr <= 8'h9f)
    else $error("config write beyond image");
  cfg_step_a: assert property (o_cfg_we && $past(o_cfg_we) |-> o_cfg_addr == $past(o_cfg_addr) + 8'h01)
    else $error("download address did not step");
endmodule // smbse_slave_chk
bind smbse_slave smbse_slave_chk #(.LOAD_CYCLES(LOAD_CYCLES)) u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_scl(i_scl), .o_sda(o_sda),
  .o_sda_oe(o_sda_oe), .o_cfg_addr(o_cfg_addr), .o_cfg_we(o_cfg_we), .o_load_busy(o_load_busy)
);
`default_nettype wire

// [smbse_mst.sv]
// Behavioural SMBus master: drives SCL, pulls SDA low through an enable
`timescale 1ns/1ps
`default_nettype none
module smbse_mst (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output var  logic o_scl,
  output var  logic o_sda_oe
);
  initial
  begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // 25-cycle bit; clock idles high outside frames
  task automatic xbit(input logic b, output logic r);
    o_scl = 1'b0;
    wt(6);
    o_sda_oe = ~b;
    wt(6);
    o_scl = 1'b1;
    wt(6);
    r = i_sda;
    wt(7);
  endtask
  task automatic start;
    wt(6);
    o_sda_oe = 1'b1;
    wt(6);
  endtask
  task automatic stop;
    o_scl = 1'b0;
    wt(6);
    o_sda_oe = 1'b1;
    wt(6);
    o_scl = 1'b1;
    wt(6);
    o_sda_oe = 1'b0;
    wt(20);
  endtask
  task automatic sbyte(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(d[i], r);
    xbit(1'b1, r);
    a = ~r;
  endtask
  // Sends the low n bytes of d, most significant first
  task automatic wr(input logic [6:0] ad, input int n, input logic [23:0] d,
                    output logic [3:0] ak);
    logic a;
    start();
    sbyte({ad, 1'b0}, a);
    ak = {3'b000, a};
    for (int k = n - 1; k >= 0; k--)
    begin
      sbyte(d[8*k +: 8], a);
      ak = {ak[2:0], a};
    end
    stop();
  endtask
  task automatic rd(input logic [6:0] ad, output logic [7:0] q, output logic a);
    logic r;
    start();
    sbyte({ad, 1'b1}, a);
    for (int i = 7; i >= 0; i--)
    begin
      xbit(1'b1, r);
      q[i] = r;
    end
    xbit(1'b1, r);
    stop();
  endtask
endmodule // smbse_mst
`default_nettype wire

// [tb_smbus_slave_eeprom_access.sv]
// Self-checking bench for the SMBus slave block
`timescale 1ns/1ps
`default_nettype none
module tb_smbus_slave_eeprom_access;
  localparam int         LOADC = 400;
  localparam logic [6:0] DEV   = 7'h44;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       ce = 1'b1;
  logic [1:0] strap = 2'b00;
  logic       seq_run = 1'b0;
  logic       rec_en = 1'b0;
  logic       rec_trig = 1'b0;
  logic       s_oe, m_oe, scl, cfg_we, busy;
  logic [7:0] cfg_addr, cfg_data, upd_cfg, q;
  logic [3:0] ak;
  logic [7:0] id [4] = '{8'h3c, 8'h07, 8'h6d, 8'h2e};
  int         err_count = 0;
  int         n_compared = 0;
  int         n_we = 0;
  wire        sda = ~(s_oe | m_oe);
  always #2.5 clk = ~clk;
  always @(posedge clk)
    if (cfg_we === 1'b1)
      n_we++;
  smbse_slave #(
    .LOAD_CYCLES(LOADC),
    .MAKER_CODE(8'h3c), .SILICON_REV(8'h07), // Arbitrary values
    .BRAND_FIRST(8'h6d), .BRAND_SECOND(8'h2e) // Arbitrary values
  ) dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_scl(scl), .i_sda(sda),
    .o_sda(), .o_sda_oe(s_oe), .i_addr_strap_high(strap[1]), .i_addr_strap_low(strap[0]),
    .i_seq_running(seq_run), .i_rec_enabled(rec_en), .i_rec_has_trigger(rec_trig),
    .o_cfg_addr(cfg_addr), .o_cfg_data(cfg_data), .o_cfg_we(cfg_we),
    .o_load_busy(busy), .o_update_cfg(upd_cfg)
  );
  smbse_mst mst (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_ack(input logic [3:0] got, input logic [3:0] exp);
    chk_val({12'h000, got}, {12'h000, exp});
  endtask
  task automatic rd_at(input int n, input logic [15:0] p, output logic [7:0] d);
    logic [3:0] k;
    logic       a;
    mst.wr(DEV, n, {8'h00, p}, k);
    mst.rd(DEV, d, a);
    chk_ack({3'b000, a}, 4'b0001);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (80000) @(negedge clk);
    err_count++;
    tally_and_finish();
  end
  initial
  begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    ce = 1'b0;
    repeat (500) @(negedge clk);
    chk_val({15'h0000, busy}, 16'h0001);
    ce = 1'b1;
    mst.wr(DEV, 1, 24'h0, ak);
    chk_ack(ak, 4'b0000);
    for (int w = 0; w < 2000 && busy !== 1'b0; w++)
      @(negedge clk);
    repeat (300) @(negedge clk);
    chk_val(n_we[15:0], 16'd160);
    for (int i = 0; i < 4; i++)
    begin
      strap = i[1:0];
      mst.wr({5'h11, i[1:0]}, 1, 24'h0, ak);
      chk_ack(ak, 4'b0011);
      mst.wr({5'h11, ~i[1:0]}, 1, 24'h0, ak);
      chk_ack(ak, 4'b0000);
    end
    strap = 2'b00;
    mst.wr(DEV, 2, 24'hf4a5, ak);
    chk_ack(ak, 4'b0111);
    for (int i = 0; i < 4; i++)
    begin
      rd_at(1, 16'h00f4 + 16'(i), q);
      chk_val({8'h00, q}, {8'h00, id[i]});
    end
    mst.wr(DEV, 2, 24'h9004, ak);
    chk_val({8'h00, upd_cfg}, 16'h0004);
    mst.wr(DEV, 2, 24'hf900, ak);
    mst.wr(DEV, 1, 24'hfe, ak);
    // Page erase keeps the slave busy for 32 cycles after the stop
    repeat (40) @(negedge clk);
    mst.wr(DEV, 3, 24'hf9005a, ak);
    chk_ack(ak, 4'b1111);
    rd_at(2, 16'hf901, q);
    chk_val({8'h00, q}, 16'h00ff);
    mst.wr(DEV, 3, 24'hf900a5, ak);
    rd_at(2, 16'hf900, q);
    chk_val({8'h00, q}, 16'h005a);
    rec_en = 1'b1;
    rec_trig = 1'b1;
    mst.wr(DEV, 3, 24'hf90277, ak);
    chk_ack(ak, 4'b1111);
    rd_at(2, 16'hf900, q);
    chk_val({8'h00, q}, 16'h0000);
    rec_trig = 1'b0;
    rd_at(2, 16'hf900, q);
    chk_val({8'h00, q}, 16'h005a);
    rd_at(2, 16'hf902, q);
    chk_val({8'h00, q}, 16'h00ff);
    rec_en = 1'b0;
    mst.wr(DEV, 2, 24'hf902, ak);
    mst.wr(DEV, 3, 24'hfc0166, ak);
    chk_ack(ak, 4'b1111);
    rd_at(2, 16'hf902, q);
    chk_val({8'h00, q}, 16'h0066);
    seq_run = 1'b1;
    mst.wr(DEV, 3, 24'hfa0033, ak);
    chk_ack(ak, 4'b1100);
    seq_run = 1'b0;
    mst.wr(DEV, 3, 24'hfa0033, ak);
    chk_ack(ak, 4'b1111);
    n_we = 0;
    mst.wr(DEV, 2, 24'hd801, ak);
    repeat (300) @(negedge clk);
    chk_val(n_we[15:0], 16'd160);
    tally_and_finish();
  end
endmodule // tb_smbus_slave_eeprom_access
`default_nettype wire
